// file: rtl/interlock_pkg.sv
// interlock_pkg: register map, field positions, reset values and mode codes
// assumes one controller clock; shared by the interlock top and its testbench
package interlock_pkg;
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] inputs_addr = 8'h04;
  localparam logic [7:0] perm_addr = 8'h08;
  localparam logic [7:0] status_addr = 8'h0c;
  localparam logic [7:0] mask_addr = 8'h10;
  // ctrl register fields
  localparam int ctrl_auto_bit = 0;
  localparam int ctrl_pendant_en_bit = 1;
  localparam int ctrl_servo_req_bit = 2;
  localparam int ctrl_brake_req_bit = 3;
  localparam int ctrl_jog_req_bit = 4;
  localparam int ctrl_run_req_bit = 5;
  localparam int ctrl_err_reset_bit = 6;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [3:0] mask_reset = 4'h0;
  // status / mask bit positions
  localparam int ev_door_err = 0;
  localparam int ev_enable_drop = 1;
  localparam int ev_servo_off = 2;
  localparam int ev_perm_denied = 3;
  localparam int ev_count = 4;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  typedef enum logic [1:0]
  {
    mode_idle_type = 2'b00,
    mode_manual_type = 2'b01,
    mode_auto_type = 2'b10
  } run_mode_type;
endpackage

// file: rtl/perm_if.sv
// perm_if: permission inputs and results passed between top and evaluator
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface perm_if;
  logic auto_mode;
  logic pendant_en;
  logic pendant_sw;
  logic enable_dev;
  logic door_closed;
  logic jog_ok;
  logic brake_ok;
  logic auto_ok;
  logic servo_ok;
  modport evaluator
  (
    input auto_mode, pendant_en, pendant_sw, enable_dev, door_closed,
    output jog_ok, brake_ok, auto_ok, servo_ok
  );
  modport owner
  (
    output auto_mode, pendant_en, pendant_sw, enable_dev, door_closed,
    input jog_ok, brake_ok, auto_ok, servo_ok
  );
endinterface

// file: rtl/perm_eval.sv
// perm_eval: purely combinational permission table
// assumes inputs are already registered and dual lines agreed upon
`timescale 1ns/1ps
module perm_eval
(
  perm_if.evaluator p
);
  logic manual_pend;
  always_comb
  begin
    manual_pend = !p.auto_mode && p.pendant_en && p.pendant_sw;
    // enabling device closed: door ignored; open: door must be closed
    p.jog_ok = manual_pend && (p.enable_dev || p.door_closed);
    p.brake_ok = manual_pend && p.enable_dev;
    p.auto_ok = p.auto_mode && !p.pendant_en && p.door_closed;
    // door open needs both switches; door closed the pendant alone
    p.servo_ok = p.auto_ok || (manual_pend && (p.enable_dev || p.door_closed));
  end
endmodule

// file: rtl/motion_interlock.sv
// motion_interlock: servo, jog, brake and automatic permission interlock
// assumes switch inputs synchronous to clk_i, dual lines wired normally closed
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module motion_interlock
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic pendant_sw_light_i,
  input wire logic pendant_sw_force_i,
  input wire logic enable_dev_a_i,
  input wire logic enable_dev_b_i,
  input wire logic door_a_i,
  input wire logic door_b_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic servo_on_o,
  output logic jog_ok_o,
  output logic brake_release_o,
  output logic auto_run_o,
  output logic fault_o,
  output logic axis_contactor_output_o,
  output logic irq_o
);
  perm_if p();
  perm_eval u_eval
  (
    .p(p)
  );

  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [3:0] status_reg;
  logic [3:0] status_next;
  logic [3:0] mask_reg;
  logic [3:0] mask_next;
  logic [4:0] in_reg;
  logic [4:0] in_next;
  logic servo_reg;
  logic servo_next;
  logic jog_reg;
  logic jog_next;
  logic brake_reg;
  logic brake_next;
  logic auto_reg;
  logic auto_next;
  logic fault_reg;
  logic fault_next;
  logic axis_contactor_control_reg;
  logic axis_contactor_control_next;
  logic irq_reg;
  logic irq_next;
  logic [3:0] events;

  // bus state
  logic aw_held_reg;
  logic aw_held_next;
  logic w_held_reg;
  logic w_held_next;
  logic [7:0] awaddr_reg;
  logic [7:0] awaddr_next;
  logic [31:0] wdata_reg;
  logic [31:0] wdata_next;
  logic [3:0] wstrb_reg;
  logic [3:0] wstrb_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic do_write;
  logic do_read;
  logic awready_reg;
  logic awready_next;
  logic wready_reg;
  logic wready_next;
  logic arready_reg;
  logic arready_next;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == interlock_pkg::ctrl_addr) || (a == interlock_pkg::inputs_addr) ||
      (a == interlock_pkg::perm_addr) || (a == interlock_pkg::status_addr) ||
      (a == interlock_pkg::mask_addr);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
    input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // input capture: dual lines must agree; one broken line reads as open
  always_comb
  begin
    in_next[0] = pendant_sw_light_i && !pendant_sw_force_i;
    in_next[1] = enable_dev_a_i && enable_dev_b_i;
    in_next[2] = door_a_i && door_b_i;
    in_next[3] = ctrl_reg[interlock_pkg::ctrl_auto_bit];
    in_next[4] = ctrl_reg[interlock_pkg::ctrl_pendant_en_bit];
  end

  assign p.pendant_sw = in_reg[0];
  assign p.enable_dev = in_reg[1];
  assign p.door_closed = in_reg[2];
  assign p.auto_mode = in_reg[3];
  assign p.pendant_en = in_reg[4];

  // permission outputs
  always_comb
  begin
    logic servo_req;
    logic err_clear;
    servo_req = ctrl_reg[interlock_pkg::ctrl_servo_req_bit];
    err_clear = do_write && (awaddr_reg == interlock_pkg::ctrl_addr) && wstrb_reg[0] &&
      wdata_reg[interlock_pkg::ctrl_err_reset_bit];
    fault_next = fault_reg;
    // door opening in automatic run is an error, held until reset with door closed
    if (auto_reg && !p.door_closed)
    begin
      fault_next = 1'b1;
    end
    else if (err_clear && p.door_closed)
    begin
      fault_next = 1'b0;
    end
    // servo withdrawn in the cycle after any condition drops
    servo_next = servo_req && p.servo_ok && !fault_next;
    jog_next = ctrl_reg[interlock_pkg::ctrl_jog_req_bit] && p.jog_ok && servo_next;
    brake_next = ctrl_reg[interlock_pkg::ctrl_brake_req_bit] && p.brake_ok;
    auto_next = ctrl_reg[interlock_pkg::ctrl_run_req_bit] && p.auto_ok && servo_next;
    // contactor follows robot servo state
    axis_contactor_control_next = servo_next;
    events = '0;
    events[interlock_pkg::ev_door_err] = fault_next && !fault_reg;
    events[interlock_pkg::ev_enable_drop] = in_reg[1] == 1'b0 && servo_reg && !p.door_closed;
    events[interlock_pkg::ev_servo_off] = servo_reg && !servo_next;
    events[interlock_pkg::ev_perm_denied] = servo_req && !p.servo_ok && !servo_reg;
  end

  // status, mask, ctrl registers
  always_comb
  begin
    logic [31:0] wmerged;
    logic [31:0] mmerged;
    wmerged = merge(32'h0000_0000, wdata_reg, wstrb_reg);
    mmerged = merge({28'h0, mask_reg}, wdata_reg, wstrb_reg);
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    if (do_write && awaddr_reg == interlock_pkg::ctrl_addr)
    begin
      ctrl_next = merge(ctrl_reg, wdata_reg, wstrb_reg);
      ctrl_next[interlock_pkg::ctrl_err_reset_bit] = 1'b0;
    end
    if (do_write && awaddr_reg == interlock_pkg::mask_addr)
    begin
      mask_next = mmerged[3:0];
    end
    if (do_write && awaddr_reg == interlock_pkg::status_addr)
    begin
      status_next = status_reg & ~wmerged[3:0];
    end
    // a new event wins over a simultaneous clear
    status_next = status_next | events;
    irq_next = |(status_next & mask_next);
  end

  // axi-lite slave: one write and one read at a time
  always_comb
  begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    do_read = s_axi_arvalid && arready_reg;
    if (s_axi_awvalid && awready_reg)
    begin
      aw_held_next = 1'b1;
      awaddr_next = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && wready_reg)
    begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (do_write)
    begin
      bvalid_next = 1'b1;
      bresp_next = mapped(awaddr_reg) ? interlock_pkg::resp_okay : interlock_pkg::resp_slverr;
    end
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
    end
    if (do_read)
    begin
      rvalid_next = 1'b1;
      rresp_next = interlock_pkg::resp_okay;
      case ({s_axi_araddr[7:2], 2'b00})
        interlock_pkg::ctrl_addr: rdata_next = ctrl_reg;
        interlock_pkg::inputs_addr: rdata_next = {27'h0, in_reg};
        interlock_pkg::perm_addr: rdata_next = {26'h0, axis_contactor_control_reg, fault_reg, auto_reg,
          brake_reg, jog_reg, servo_reg};
        interlock_pkg::status_addr: rdata_next = {28'h0, status_reg};
        interlock_pkg::mask_addr: rdata_next = {28'h0, mask_reg};
        default:
        begin
          rdata_next = 32'h0000_0000;
          rresp_next = interlock_pkg::resp_slverr;
        end
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
    // a slot reopens only once its response is taken, so nothing is captured twice
    awready_next = !aw_held_next;
    wready_next = !w_held_next;
    arready_next = !rvalid_next;
  end

  // registers; clock enable freezes every state element
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_reg <= interlock_pkg::ctrl_reset;
      mask_reg <= interlock_pkg::mask_reset;
      status_reg <= 4'h0;
      in_reg <= 5'h00;
      servo_reg <= 1'b0;
      jog_reg <= 1'b0;
      brake_reg <= 1'b0;
      auto_reg <= 1'b0;
      fault_reg <= 1'b0;
      axis_contactor_control_reg <= 1'b0;
      irq_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      arready_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      status_reg <= status_next;
      in_reg <= in_next;
      servo_reg <= servo_next;
      jog_reg <= jog_next;
      brake_reg <= brake_next;
      auto_reg <= auto_next;
      fault_reg <= fault_next;
      axis_contactor_control_reg <= axis_contactor_control_next;
      irq_reg <= irq_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      arready_reg <= arready_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign servo_on_o = servo_reg;
  assign jog_ok_o = jog_reg;
  assign brake_release_o = brake_reg;
  assign auto_run_o = auto_reg;
  assign fault_o = fault_reg;
  assign axis_contactor_output_o = axis_contactor_control_reg;
  assign irq_o = irq_reg;
endmodule

// file: bench/operator_switches.sv
// operator_switches: pendant grip switch, enabling device and door contacts
// assumes bench commands change just after a clock edge
`timescale 1ns/1ps
module operator_switches
(
  input wire logic clk_i,
  input wire logic [1:0] grip_i,
  input wire logic hold_en_i,
  input wire logic shut_i,
  input wire logic split_i,
  output logic light_o = 1'b0,
  output logic force_o = 1'b0,
  output logic ena_a_o = 1'b0,
  output logic ena_b_o = 1'b0,
  output logic door_a_o = 1'b0,
  output logic door_b_o = 1'b0
);
  // contacts settle one edge after the hand moves; split opens channel b only
  always @(posedge clk_i)
  begin
    light_o <= grip_i == 2'h1;
    force_o <= grip_i == 2'h2;
    ena_a_o <= hold_en_i;
    ena_b_o <= hold_en_i & !split_i;
    door_a_o <= shut_i;
    door_b_o <= shut_i & !split_i;
  end
endmodule

// file: bench/motion_interlock_chk.sv
// motion_interlock_chk: port assertions on the permission outputs
// assumes clk_en_i high and switch inputs synchronous to clk_i
`timescale 1ns/1ps
module motion_interlock_chk
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic pendant_sw_light_i,
  input wire logic pendant_sw_force_i,
  input wire logic enable_dev_a_i,
  input wire logic enable_dev_b_i,
  input wire logic door_a_i,
  input wire logic door_b_i,
  input wire logic servo_on_o,
  input wire logic jog_ok_o,
  input wire logic brake_release_o,
  input wire logic auto_run_o,
  input wire logic fault_o,
  input wire logic axis_contactor_output_o
);
  wire logic ena = enable_dev_a_i & enable_dev_b_i;
  wire logic door = door_a_i & door_b_i;
  wire logic mid = pendant_sw_light_i & !pendant_sw_force_i;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i || !clk_en_i);
  // input and output registers: two edges from switch to permission
  chk_servo_guard:
    assert property (!door && !ena |-> ##2 !servo_on_o) else $error("servo left on");
  chk_brake_enable:
    assert property ((!ena) [*2] |=> !brake_release_o) else $error("brake freed");
  chk_mid_grip:
    assert property (!mid |-> ##2 !(jog_ok_o || brake_release_o)) else $error("grip");
  chk_jog_door:
    assert property ((!ena && !door) [*2] |=> !jog_ok_o) else $error("jog unguarded");
  chk_jog_servo:
    assert property (jog_ok_o |-> servo_on_o || $past(servo_on_o)) else $error("jog");
  chk_auto_door:
    assert property (!door |-> ##2 !auto_run_o) else $error("auto run door open");
  chk_door_fault:
    assert property (auto_run_o && !door |-> ##[1:3] (fault_o && !servo_on_o))
    else $error("no fault on door");
  chk_fault_cause:
    assert property ($rose(fault_o) |-> $past(auto_run_o)) else $error("fault cause");
  chk_contact_open:
    assert property (!servo_on_o |-> !axis_contactor_output_o) else $error("contactor");
  chk_contact_close:
    assert property (servo_on_o [*2] |-> axis_contactor_output_o) else $error("contact");
  cov_teach: cover property (servo_on_o && !door_a_i);
  cov_brake: cover property (brake_release_o);
  cov_auto: cover property (auto_run_o);
  cov_fault: cover property ($rose(fault_o));
endmodule
bind motion_interlock motion_interlock_chk chk_u
(
  .clk_i, .sys_rst_i, .clk_en_i, .pendant_sw_light_i, .pendant_sw_force_i,
  .enable_dev_a_i, .enable_dev_b_i, .door_a_i, .door_b_i, .servo_on_o, .jog_ok_o,
  .brake_release_o, .auto_run_o, .fault_o, .axis_contactor_output_o
);

// file: bench/robot_safety_motion_interlock_test.sv
// robot_safety_motion_interlock_test: directed and random interlock checks
// assumes two edges from switch to output and axi answers within 64 edges
`timescale 1ns/1ps
module robot_safety_motion_interlock_test;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic br = 1'b0;
  logic arv = 1'b0;
  logic rr = 1'b0;
  logic [1:0] grip = 2'h0;
  logic hold = 1'b0;
  logic shut = 1'b0;
  logic split = 1'b0;
  logic flt = 1'b0;
  logic [5:0] ctrl = 6'h0;
  logic [5:0] want = 6'h0;
  logic [31:0] seed = 32'habe8a506;
  logic [31:0] rdat;
  logic [1:0] rresp;
  int num_errors = 0;
  int cmp_count = 0;
  logic awr, wrd, bv, arr, rv, lt, fc, ea, eb, da, db, irq;
  logic [31:0] rdw;
  logic [1:0] rrs;
  logic [1:0] brs;
  logic cen = 1'b1;
  wire [5:0] outs;
  always #2.5 clk_i = ~clk_i;
  operator_switches ops
  (
    .clk_i(clk_i), .grip_i(grip), .hold_en_i(hold), .shut_i(shut), .split_i(split),
    .light_o(lt), .force_o(fc), .ena_a_o(ea), .ena_b_o(eb), .door_a_o(da), .door_b_o(db)
  );
  motion_interlock uut
  (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(cen), .pendant_sw_light_i(lt),
    .pendant_sw_force_i(fc), .enable_dev_a_i(ea), .enable_dev_b_i(eb), .door_a_i(da),
    .door_b_i(db), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdw), .s_axi_rresp(rrs),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .servo_on_o(outs[0]), .jog_ok_o(outs[1]),
    .brake_release_o(outs[2]), .auto_run_o(outs[3]), .fault_o(outs[4]),
    .axis_contactor_output_o(outs[5]), .irq_o(irq)
  );
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // {contactor, fault, auto run, brake, jog, servo}
  function automatic logic [5:0] expect_perm(input logic [5:0] c, input logic sw, e, dr, f);
    logic aut;
    logic man;
    logic srv;
    aut = c[0] & !c[1] & dr;
    man = !c[0] & c[1] & sw;
    srv = c[2] & (aut | (man & (e | dr))) & !f;
    return {srv, f, c[5] & aut & srv, c[3] & man & e, c[4] & man & (e | dr) & srv, srv};
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer at a time, so write and read share one handshake loop
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awa <= a;
    ara <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    br <= w;
    arv <= !w;
    rr <= !w;
    do
    begin
      @(posedge clk_i);
      n++;
      if (awr)
        awv <= 1'b0;
      if (wrd)
        wv <= 1'b0;
      if (arr)
        arv <= 1'b0;
    end
    while ((w ? bv : rv) !== 1'b1 && n < 64);
    rdat = rdw;
    rresp = w ? brs : rrs;
    br <= 1'b0;
    rr <= 1'b0;
    if (n >= 64)
    begin
      num_errors++;
      $display("wait ran out at %0t", $time);
      final_report();
    end
    // one edge passes so the next call never reassigns bready or rready at once
    @(posedge clk_i);
  endtask
  // move the switches under the old control word, then write the new one
  task automatic step(input logic [1:0] g, input logic e, dr, sp, input logic [6:0] c);
    logic dok;
    logic eok;
    dok = dr & !sp;
    eok = e & !sp;
    grip <= g;
    hold <= e;
    shut <= dr;
    split <= sp;
    repeat (5) @(posedge clk_i);
    if (want[3] && !dok)
      flt = 1'b1;
    want = expect_perm(ctrl, g == 2'h1, eok, dok, flt);
    chk({26'h0, outs}, {26'h0, want});
    bus(1'b1, interlock_pkg::ctrl_addr, {25'h0, c});
    ctrl = c[5:0];
    if (c[6] && dok)
      flt = 1'b0;
    repeat (5) @(posedge clk_i);
    want = expect_perm(ctrl, g == 2'h1, eok, dok, flt);
    chk({26'h0, outs}, {26'h0, want});
    bus(1'b0, interlock_pkg::perm_addr, 32'h0);
    chk(rdat, {26'h0, want});
  endtask
  initial
  begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, interlock_pkg::ctrl_addr, 32'h0);
    chk(rdat, interlock_pkg::ctrl_reset);
    bus(1'b0, interlock_pkg::mask_addr, 32'h0);
    chk(rdat, {28'h0, interlock_pkg::mask_reset});
    bus(1'b0, 8'h14, 32'h0);
    chk({30'h0, rresp}, {30'h0, interlock_pkg::resp_slverr});
    chk(rdat, 32'h0);
    bus(1'b1, 8'h14, 32'h0);
    chk({30'h0, rresp}, {30'h0, interlock_pkg::resp_slverr});
    bus(1'b1, interlock_pkg::ctrl_addr, 32'h0);
    chk({30'h0, rresp}, {30'h0, interlock_pkg::resp_okay});
    $display("test registers done");
    step(2'h1, 1'b1, 1'b0, 1'b0, 7'h1e);
    step(2'h1, 1'b0, 1'b0, 1'b0, 7'h1e);
    step(2'h2, 1'b1, 1'b0, 1'b0, 7'h1e);
    step(2'h1, 1'b0, 1'b1, 1'b0, 7'h16);
    step(2'h0, 1'b0, 1'b1, 1'b0, 7'h25);
    step(2'h0, 1'b0, 1'b0, 1'b0, 7'h25);
    step(2'h0, 1'b0, 1'b1, 1'b0, 7'h65);
    $display("test directed done");
    repeat (300)
    begin
      seed = xs(seed);
      step(seed[1:0] == 2'h3 ? 2'h1 : seed[1:0], seed[2], seed[3], seed[7:4] == 4'h0,
        seed[14:8]);
    end
    $display("test random done");
    // a refused servo request is held back by the mask, then raises the line
    step(2'h0, 1'b0, 1'b0, 1'b0, 7'h02);
    bus(1'b1, interlock_pkg::mask_addr, 32'h0);
    bus(1'b1, interlock_pkg::status_addr, 32'hf);
    bus(1'b1, interlock_pkg::ctrl_addr, 32'h6);
    repeat (5) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, interlock_pkg::mask_addr, 32'h8);
    repeat (5) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, interlock_pkg::status_addr, 32'h0);
    chk({31'h0, rdat[3]}, 32'h1);
    bus(1'b1, interlock_pkg::ctrl_addr, 32'h2);
    bus(1'b1, interlock_pkg::status_addr, 32'h8);
    repeat (5) @(posedge clk_i);
    bus(1'b0, interlock_pkg::status_addr, 32'h0);
    chk({31'h0, rdat[3]}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupts done");
    // clock enable low: switches drop but every output holds its last value
    step(2'h1, 1'b1, 1'b1, 1'b0, 7'h56);
    cen <= 1'b0;
    hold <= 1'b0;
    shut <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk({26'h0, outs}, {26'h0, want});
    cen <= 1'b1;
    repeat (5) @(posedge clk_i);
    want = expect_perm(ctrl, 1'b1, 1'b0, 1'b0, flt);
    chk({26'h0, outs}, {26'h0, want});
    $display("test clock enable done");
    final_report();
  end
endmodule
